// [hw/eebk_pkg.sv]
// Shared constants for the bank select and EEPROM write controller
package eebk_pkg;
  // ----------------------------------------
  // Data-space map
  // ----------------------------------------
  localparam logic [7:0] BANK_SELECT_ADDR = 8'he8;
  localparam logic [7:0] EE_CTRL_ADDR = 8'hea;
  localparam logic [1:0] BANK_REGION_TOP = 2'h0; // Addr[7:6] of 00h..3Fh
  localparam int PAGE_BYTES = 64;
  localparam int EE_PAGES = 2;
  localparam int ROW_BYTES = 8;

  // ----------------------------------------
  // Bank select values and bits
  // ----------------------------------------
  localparam logic [7:0] BANK_NONE = 8'h00;
  localparam logic [7:0] BANK_EE_PAGE0 = 8'h01;
  localparam logic [7:0] BANK_EE_PAGE1 = 8'h02;
  localparam logic [7:0] BANK_RAM_PAGE2 = 8'h10;

  // ----------------------------------------
  // EEPROM control register fields
  // ----------------------------------------
  localparam int EE_STANDBY_BIT = 6;
  localparam int ROW_WRITE_START_BIT = 3;
  localparam int ROW_MODE_ENABLE_BIT = 2;
  localparam int PROG_BUSY_BIT = 1;
  localparam int PROG_ENABLE_BIT = 0;
  localparam logic [7:0] EE_CTRL_RESET = 8'h00;
  localparam logic [7:0] UNDEF_READ = 8'hff; // Value for meaningless reads

  // ----------------------------------------
  // Programming duration
  // ----------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int PROG_TIME_US = 5;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

  // ----------------------------------------
  // Controller APB map
  // ----------------------------------------
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_STOP = 8'h08;
  localparam int CMD_WE_BIT = 16;
  localparam int STATUS_PEND_BIT = 8;
endpackage

// [hw/eebk_bus_if.sv]
// Data-space bus between CPU side and bank/EEPROM block
`timescale 1ns/100ps
interface eebk_bus_if;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  logic stop;

  modport cpu (output req, output we, output addr, output wdata,
    output stop, input ack, input rdata);
  modport dev (input req, input we, input addr, input wdata,
    input stop, output ack, output rdata);
endinterface

// [hw/eebk_device.sv]
// Bank select register, paged RAM/EEPROM and EEPROM write control
// Function
// RQ1: Bank value picks RAM2, EE0, EE1.
// RQ2: 00h-3Fh maps to selected page.
// RQ3: Bank register write-only at E8h, bytes.
// RQ4: Bank register untouched by reset.
// RQ5: Software sets one bank bit only.
// RQ6: Standby bit disables EEPROM accesses.
// RQ7: No EEPROM bank: accesses meaningless.
// RQ8: Busy during cycle; accesses aborted.
// RQ9: Control writes ignored while busy.
// RQ10: Write cycle needs programming enable.
// RQ11: Idle EEPROM reads like plain RAM.
// RQ12: Byte mode and row mode writes.
// RQ13: Row is A7..A3, byte A2..A0; the row latch takes ee_index[6:3] (page bit, A5..A3).
// RQ14: Row mode enable clears latches.
// RQ15: Only written row bytes programmed.
// RQ16: Start needs enable and row mode.
// RQ17: Row cycle end clears mode, start.
// RQ18: Clearing row mode abandons row.
// RQ19: No reads/other rows in row mode.
// RQ20: No page change in row mode.
// RQ21: STOP disables the EEPROM.
// RQ22: Control resets 00h; bits 4,5 reserved.
// RQ23: Busy set on accept, cleared by counter.
`timescale 1ns/100ps
module eebk_device
  import eebk_pkg::*;
#(
  parameter int PROG_LEN = PROG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  eebk_bus_if.dev bus,
  output logic prog_busy
);
  localparam int EE_BYTES = EE_PAGES * PAGE_BYTES;
  localparam int CW = $clog2(PROG_LEN + 1);

  typedef enum logic [1:0] {
    EEBK_IDLE,
    EEBK_BYTE,
    EEBK_ROW
  } eebk_state_t;

  logic [7:0] ram_page2 [PAGE_BYTES];
  logic [7:0] ee_cells [EE_BYTES];
  logic [7:0] bank_select_reg;
  logic ee_standby;
  logic row_write_start;
  logic row_mode_enable;
  logic prog_enable;
  eebk_state_t state;
  logic [CW-1:0] prog_cnt;
  logic [6:0] byte_addr;
  logic [7:0] byte_data;
  logic row_latched;
  logic [3:0] row_addr;
  logic [7:0] row_data [ROW_BYTES];
  logic [ROW_BYTES-1:0] row_written;
  logic ack;
  logic [7:0] rdata;

  logic in_region;
  logic ram_sel;
  logic ee_sel;
  logic [6:0] ee_index;
  logic ee_usable;
  logic wr_ctrl;
  logic wr_ee;
  logic start_ok;
  logic prog_done;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign in_region = bus.addr[7:6] == BANK_REGION_TOP; // RQ2
  assign ram_sel = bank_select_reg == BANK_RAM_PAGE2; // RQ1
  assign ee_sel = bank_select_reg == BANK_EE_PAGE0 ||
    bank_select_reg == BANK_EE_PAGE1; // RQ1 RQ7
  assign ee_index = {bank_select_reg == BANK_EE_PAGE1, bus.addr[5:0]};
  // EEPROM reachable only when selected, awake, idle and not stopped
  assign ee_usable = ee_sel && !ee_standby && !bus.stop &&
    state == EEBK_IDLE; // RQ6 RQ8 RQ21
  assign wr_ctrl = bus.req && bus.we && bus.addr == EE_CTRL_ADDR &&
    state == EEBK_IDLE; // RQ9
  assign wr_ee = bus.req && bus.we && in_region && ee_usable;
  // Start accepted only with enable and row mode both set
  assign start_ok = bus.wdata[ROW_WRITE_START_BIT] &&
    bus.wdata[PROG_ENABLE_BIT] && bus.wdata[ROW_MODE_ENABLE_BIT] &&
    row_mode_enable; // RQ16
  assign prog_done = state != EEBK_IDLE &&
    prog_cnt == CW'(PROG_LEN - 1);

  // ----------------------------------------
  // Bank select register, no reset
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (bus.req && bus.we && bus.addr == BANK_SELECT_ADDR) begin
      bank_select_reg <= bus.wdata; // RQ3 RQ4
    end
  end

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_standby <= EE_CTRL_RESET[EE_STANDBY_BIT]; // RQ22
      row_mode_enable <= EE_CTRL_RESET[ROW_MODE_ENABLE_BIT];
      row_write_start <= EE_CTRL_RESET[ROW_WRITE_START_BIT];
      prog_enable <= EE_CTRL_RESET[PROG_ENABLE_BIT];
    end else if (prog_done && state == EEBK_ROW) begin
      row_mode_enable <= 1'b0; // RQ17
      row_write_start <= 1'b0; // RQ17
    end else if (wr_ctrl) begin
      // Bits 4, 5 and 7 are not stored
      ee_standby <= bus.wdata[EE_STANDBY_BIT]; // RQ6
      row_mode_enable <= bus.wdata[ROW_MODE_ENABLE_BIT];
      prog_enable <= bus.wdata[PROG_ENABLE_BIT]; // RQ10
      row_write_start <= start_ok; // RQ16
    end
  end

  // ----------------------------------------
  // Programming sequencer and busy counter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= EEBK_IDLE;
      prog_cnt <= '0;
      byte_addr <= '0;
      byte_data <= '0;
    end else begin
      case (state)
        EEBK_IDLE: begin
          prog_cnt <= '0;
          if (wr_ctrl && start_ok) begin
            state <= EEBK_ROW; // RQ12 RQ23
          end else if (wr_ee && prog_enable && !row_mode_enable) begin
            state <= EEBK_BYTE; // RQ10 RQ12 RQ23
            byte_addr <= ee_index;
            byte_data <= bus.wdata;
          end
        end
        EEBK_BYTE, EEBK_ROW: begin
          if (prog_done) begin
            state <= EEBK_IDLE; // RQ23
          end else begin
            prog_cnt <= prog_cnt + CW'(1);
          end
        end
        default: state <= EEBK_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Row latches
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      row_latched <= 1'b0;
      row_addr <= '0;
      row_written <= '0;
    end else if (!row_mode_enable || (wr_ctrl &&
        !bus.wdata[ROW_MODE_ENABLE_BIT])) begin
      row_latched <= 1'b0; // RQ18
      row_written <= '0; // RQ14
    end else if (wr_ee && (!row_latched ||
        row_addr == ee_index[6:3])) begin
      row_latched <= 1'b1; // RQ13
      row_addr <= ee_index[6:3]; // RQ13 RQ19
      row_written[ee_index[2:0]] <= 1'b1;
    end
  end

  // Row data, cleared whenever row mode is off
  for (genvar i = 0; i < ROW_BYTES; i++) begin : g_row
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        row_data[i] <= '0;
      end else if (!row_mode_enable) begin
        row_data[i] <= '0; // RQ14
      end else if (wr_ee && ee_index[2:0] == 3'(i) && (!row_latched ||
          row_addr == ee_index[6:3])) begin
        row_data[i] <= bus.wdata;
      end
    end
  end

  // ----------------------------------------
  // EEPROM cells, committed at cycle end
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (prog_done && state == EEBK_BYTE) begin
      ee_cells[byte_addr] <= byte_data; // RQ12
    end
    if (prog_done && state == EEBK_ROW) begin
      for (int j = 0; j < ROW_BYTES; j++) begin
        if (row_written[j]) begin
          ee_cells[{row_addr, 3'(j)}] <= row_data[j]; // RQ15
        end
      end
    end
  end

  // ----------------------------------------
  // RAM page 2
  // ----------------------------------------
  always_ff @(posedge pclk) begin
    if (bus.req && bus.we && in_region && ram_sel) begin
      ram_page2[bus.addr[5:0]] <= bus.wdata; // RQ2
    end
  end

  // ----------------------------------------
  // Read data and acknowledge, one cycle after request
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= bus.req;
      if (bus.req && !bus.we) begin
        if (bus.addr == EE_CTRL_ADDR) begin
          rdata <= 8'(state != EEBK_IDLE) << PROG_BUSY_BIT; // RQ8 RQ9
        end else if (in_region && ram_sel) begin
          rdata <= ram_page2[bus.addr[5:0]];
        end else if (in_region && ee_usable && !row_mode_enable) begin
          rdata <= ee_cells[ee_index]; // RQ11
        end else if (in_region) begin
          rdata <= UNDEF_READ; // RQ7
        end else begin
          rdata <= '0; // RQ3
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_busy <= 1'b0;
    end else begin
      prog_busy <= (state != EEBK_IDLE && !prog_done) ||
        (state == EEBK_IDLE && ((wr_ctrl && start_ok) ||
        (wr_ee && prog_enable && !row_mode_enable))); // RQ8
    end
  end

  assign bus.ack = ack;
  assign bus.rdata = rdata;
endmodule

// [hw/eebk_cpu.sv]
// CPU-side controller: APB orders become data-space accesses
`timescale 1ns/100ps
module eebk_cpu
  import eebk_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  eebk_bus_if.cpu bus
);
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic stop;
  logic pending;
  logic [7:0] last_rdata;
  logic access;
  logic mapped;

  // ----------------------------------------
  // APB decode, answer one cycle into access
  // ----------------------------------------
  assign access = psel && penable && !pready;
  assign mapped = paddr == APB_CMD || paddr == APB_STATUS ||
    paddr == APB_STOP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      prdata <= '0;
      if (access && !pwrite && paddr == APB_STATUS) begin
        prdata <= {23'h0, pending, last_rdata};
      end else if (access && !pwrite && paddr == APB_STOP) begin
        prdata <= {31'h0, stop};
      end
    end
  end

  // ----------------------------------------
  // Command issue and completion
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= 1'b0;
      we <= 1'b0;
      addr <= '0;
      wdata <= '0;
      pending <= 1'b0;
      last_rdata <= '0;
      stop <= 1'b0;
    end else begin
      req <= 1'b0;
      if (access && pwrite && paddr == APB_CMD && !pending) begin
        req <= 1'b1;
        pending <= 1'b1;
        we <= pwdata[CMD_WE_BIT];
        addr <= pwdata[15:8];
        wdata <= pwdata[7:0];
      end else if (pending && bus.ack) begin
        pending <= 1'b0;
        if (!we) begin
          last_rdata <= bus.rdata;
        end
      end
      if (access && pwrite && paddr == APB_STOP) begin
        stop <= pwdata[0];
      end
    end
  end

  assign bus.req = req;
  assign bus.we = we;
  assign bus.addr = addr;
  assign bus.wdata = wdata;
  assign bus.stop = stop;
endmodule

// [testbench/eebk_checker.sv]
// Protocol and busy checks on the data-space bus between the two ends
`timescale 1ns/100ps
module eebk_checker
  import eebk_pkg::*;
#(
  parameter int PROG_LEN = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata,
  input wire logic stop,
  input wire logic prog_busy
);
  // ----------------------------------------
  // Bus answer timing
  // ----------------------------------------
  // Busy stands PROG_LEN cycles, low on the one after
  localparam int BUSY_END = PROG_LEN + 1;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ack_follows_req: assert property (req |=> ack)
    else $error("no answer one cycle after request");
  chk_ack_has_cause: assert property (ack |-> $past(req))
    else $error("answer without request");
  chk_rdata_write_hold: assert property (
    ack && $past(req && we) |-> $stable(rdata))
    else $error("read data moved on a write");

  // ----------------------------------------
  // Register read-back
  // ----------------------------------------
  chk_ctrl_read_busy: assert property (
    ack && $past(req && !we && addr == EE_CTRL_ADDR)
    |-> rdata[7:2] == 6'h00 && rdata[0] == 1'b0)
    else $error("control read shows write-only bits");
  chk_bank_write_only: assert property (
    ack && $past(req && !we && addr == BANK_SELECT_ADDR)
    |-> rdata == 8'h00)
    else $error("bank register readable");

  // ----------------------------------------
  // Programming busy window
  // ----------------------------------------
  chk_busy_has_write: assert property (
    $rose(prog_busy) |-> $past(req && we && (addr[7:6] == 2'h0
    || addr == EE_CTRL_ADDR)))
    else $error("busy without a write");
  chk_busy_holds: assert property ($rose(prog_busy) |-> prog_busy[*8])
    else $error("busy dropped early");
  chk_busy_ends: assert property (
    $rose(prog_busy) |-> ##[1:BUSY_END] !prog_busy)
    else $error("busy never ends");
  chk_start_bits: assert property (
    $rose(prog_busy) && $past(addr == EE_CTRL_ADDR)
    |-> $past(wdata[ROW_WRITE_START_BIT] && wdata[ROW_MODE_ENABLE_BIT]
    && wdata[PROG_ENABLE_BIT]))
    else $error("row cycle without start bits");
  chk_stop_no_write: assert property (
    $rose(prog_busy) && $past(addr[7:6] == 2'h0) |-> !$past(stop))
    else $error("programming started while stopped");
endmodule

// [testbench/test_eeprom_bank_controller.sv]
// Testbench joining CPU side and device side through the APB controller
`timescale 1ns/100ps
module test_eeprom_bank_controller;
  import eebk_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, rd;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, prog_busy, perr;
  int failures = 0, checked = 0;
  logic [25:0] rows [10] = '{
    {2'b01, 8'he8, 8'h10, 8'h00}, {2'b01, 8'h05, 8'ha5, 8'h00},
    {2'b10, 8'h05, 8'h00, 8'ha5}, {2'b10, 8'he8, 8'h00, 8'h00},
    {2'b10, 8'hea, 8'h00, 8'h00}, {2'b01, 8'he8, 8'h00, 8'h00},
    {2'b10, 8'h05, 8'h00, 8'hff}, {2'b01, 8'he8, 8'h10, 8'h00},
    {2'b10, 8'h05, 8'h00, 8'ha5}, {2'b01, 8'he8, 8'h01, 8'h00}};

  eebk_bus_if eebk_bus_if_i();
  eebk_device #(.PROG_LEN(40)) eebk_device_i(.pclk(pclk),
    .presetn(presetn), .bus(eebk_bus_if_i.dev), .prog_busy(prog_busy));
  eebk_cpu eebk_cpu_i(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus(eebk_bus_if_i.cpu));
  eebk_checker #(.PROG_LEN(40)) eebk_checker_i(.pclk(pclk),
    .presetn(presetn), .req(eebk_bus_if_i.req), .we(eebk_bus_if_i.we),
    .addr(eebk_bus_if_i.addr), .wdata(eebk_bus_if_i.wdata),
    .ack(eebk_bus_if_i.ack), .rdata(eebk_bus_if_i.rdata),
    .stop(eebk_bus_if_i.stop), .prog_busy(prog_busy));

  // ----------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------
  initial begin
    forever #20 pclk = ~pclk;
  end
  task print_verdict;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    print_verdict;
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task check(input string name, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // Request held until pready is seen high at a rising edge
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    perr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // One data-space access, waiting until the controller is done
  task dsp(input logic w, input logic [7:0] a, d);
    apb(1, APB_CMD, {15'h0, w, a, d});
    do apb(0, APB_STATUS, 32'h0); while (r[STATUS_PEND_BIT] !== 1'b0);
    rd = r[7:0];
  endtask
  task idle;
    do dsp(0, EE_CTRL_ADDR, 8'h00); while (rd[1] !== 1'b0);
  endtask
  task reset;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset;
    foreach (rows[i]) begin
      dsp(rows[i][24], rows[i][23:16], rows[i][15:8]);
      if (rows[i][25]) check("row", rd, rows[i][7:0]);
    end
    apb(0, 8'h0c, 32'h0);
    check("pslverr", {7'h0, perr}, 8'h01);
    // Byte mode write, busy, abort of read while busy
    dsp(1, EE_CTRL_ADDR, 8'h01);
    dsp(1, 8'h07, 8'h5a);
    dsp(0, EE_CTRL_ADDR, 8'h00);
    check("busy", rd, 8'h02);
    check("busy pin", {7'h0, prog_busy}, 8'h01);
    dsp(0, 8'h07, 8'h00);
    check("busy read", rd, UNDEF_READ);
    idle;
    check("idle pin", {7'h0, prog_busy}, 8'h00);
    dsp(0, 8'h07, 8'h00);
    check("byte", rd, 8'h5a);
    // No programming without enable
    dsp(1, EE_CTRL_ADDR, 8'h00);
    dsp(1, 8'h07, 8'h11);
    dsp(0, EE_CTRL_ADDR, 8'h00);
    check("no enable", rd, 8'h00);
    dsp(0, 8'h07, 8'h00);
    check("kept", rd, 8'h5a);
    // Control write while busy is dropped
    dsp(1, EE_CTRL_ADDR, 8'h01);
    dsp(1, 8'h1c, 8'hc3);
    dsp(1, EE_CTRL_ADDR, 8'h40);
    idle;
    dsp(0, 8'h1c, 8'h00);
    check("busy ctrl", rd, 8'hc3);
    dsp(1, EE_CTRL_ADDR, 8'h40);
    dsp(0, 8'h1c, 8'h00);
    check("standby", rd, UNDEF_READ);
    // Row mode: partial row, others untouched
    dsp(1, EE_CTRL_ADDR, 8'h05);
    dsp(1, 8'h18, 8'ha1);
    dsp(1, 8'h1a, 8'ha2);
    dsp(0, 8'h1a, 8'h00);
    check("row read", rd, UNDEF_READ);
    dsp(1, EE_CTRL_ADDR, 8'h0d);
    idle;
    dsp(0, 8'h18, 8'h00);
    check("row 18", rd, 8'ha1);
    dsp(0, 8'h1a, 8'h00);
    check("row 1a", rd, 8'ha2);
    dsp(0, 8'h1c, 8'h00);
    check("row 1c", rd, 8'hc3);
    // Row mode cleared at end; abandon keeps cells
    dsp(1, EE_CTRL_ADDR, 8'h0d);
    dsp(0, EE_CTRL_ADDR, 8'h00);
    check("no start", rd, 8'h00);
    dsp(1, 8'h18, 8'h00);
    dsp(1, EE_CTRL_ADDR, 8'h01);
    dsp(0, 8'h18, 8'h00);
    check("abandon", rd, 8'ha1);
    // Page 1 is a separate array
    dsp(1, BANK_SELECT_ADDR, BANK_EE_PAGE1);
    dsp(1, 8'h18, 8'h3c);
    idle;
    dsp(0, 8'h18, 8'h00);
    check("page 1", rd, 8'h3c);
    dsp(1, BANK_SELECT_ADDR, BANK_EE_PAGE0);
    dsp(0, 8'h18, 8'h00);
    check("page 0", rd, 8'ha1);
    // Stop disables the array
    apb(1, APB_STOP, 32'h1);
    dsp(0, 8'h18, 8'h00);
    check("stop", rd, UNDEF_READ);
    dsp(1, 8'h18, 8'h77);
    apb(1, APB_STOP, 32'h0);
    dsp(0, 8'h18, 8'h00);
    check("stop write", rd, 8'ha1);
    // Second reset keeps the bank choice, clears control
    reset;
    dsp(0, EE_CTRL_ADDR, 8'h00);
    check("ctrl reset", rd, EE_CTRL_RESET);
    dsp(0, 8'h18, 8'h00);
    check("bank kept", rd, 8'ha1);
    print_verdict;
  end
endmodule
